// ---- inc/rmsu_pkg.sv ----
// Constants, register map and operation codes of the rotate, mask and shift unit
package rmsu_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int CNT_W  = 5;
   localparam int BYTE_W = 8;
   localparam int STRB_W = DATA_W / BYTE_W;

   // Instruction fields; the most significant instruction bit is our bit 31
   localparam int OPCD_HI  = 31;
   localparam int OPCD_LO  = 26;
   localparam int TGT_HI   = 20;
   localparam int TGT_LO   = 16;
   localparam int ROT_HI   = 15;
   localparam int ROT_LO   = 11;
   localparam int MBEG_HI  = 10;
   localparam int MBEG_LO  = 6;
   localparam int MEND_HI  = 5;
   localparam int MEND_LO  = 1;
   localparam int XO_HI    = 10;
   localparam int XO_LO    = 1;
   localparam int REC_BIT  = 0;
   localparam int SIGN_BIT = 31;

   // Amount operand: count in the low five bits, overflow bit above them
   localparam int AMT_HI   = 4;
   localparam int AMT_LO   = 0;
   localparam int AMT_OVER = 5;

   localparam logic [5:0] OPCD_INSERT  = 6'h14;
   localparam logic [5:0] OPCD_AND_IMM = 6'h15;
   localparam logic [5:0] OPCD_AND_REG = 6'h17;
   localparam logic [5:0] OPCD_EXT     = 6'h1f;
   localparam logic [9:0] XO_SLW       = 10'h018;
   localparam logic [9:0] XO_SRAW      = 10'h318;

   localparam logic [CNT_W-1:0] MASK_FIRST = 5'h00;
   localparam logic [CNT_W-1:0] MASK_LAST  = 5'h1f;
   localparam logic [CNT_W:0]   ROT_WRAP   = 6'h20;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INSTR  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SRC    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TGT    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_AMT    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_EXC    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_COND   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

   // Fixed-point exception register bits
   localparam int EXC_W  = 2;
   localparam int EXC_CY = 0;
   localparam int EXC_SO = 1;

   // Condition field zero bits
   localparam int CR_W  = 4;
   localparam int CR_LT = 3;
   localparam int CR_GT = 2;
   localparam int CR_EQ = 1;
   localparam int CR_SO = 0;

   // Status register bits
   localparam int ST_DONE    = 0;
   localparam int ST_ILLEGAL = 1;
   localparam int ST_TGT_LO  = 8;
   localparam int ST_TGT_HI  = 12;

   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_INSERT,
      OP_AND_IMM,
      OP_AND_REG,
      OP_SLW,
      OP_SRAW
   } rmsu_op_e;

endpackage

// ---- src/rmsu_mask_gen.sv ----
// Run-of-ones mask generator with wrap-around
`timescale 1ns/1ps
module rmsu_mask_gen (
   input  wire logic [rmsu_pkg::CNT_W-1:0]  mask_begin,
   input  wire logic [rmsu_pkg::CNT_W-1:0]  mask_end,
   input  wire logic                        mask_zero,
   output logic      [rmsu_pkg::DATA_W-1:0] mask
);
   import rmsu_pkg::*;

   logic [CNT_W-1:0] pos;

   // Positions count from the most significant bit, as in the encoding
   always_comb begin
      mask = '0;
      pos  = '0;
      for (int i = 0; i < DATA_W; i++) begin
         pos = CNT_W'(i);
         if (mask_zero) begin
            mask[DATA_W-1-i] = 1'b0;
         end else if (mask_begin <= mask_end) begin
            mask[DATA_W-1-i] = (pos >= mask_begin) && (pos <= mask_end); // [RQ1]
         end else begin
            mask[DATA_W-1-i] = (pos >= mask_begin) || (pos <= mask_end); // [RQ2]
         end
      end
   end

endmodule // rmsu_mask_gen

// ---- src/rmsu_rotl.sv ----
// 32-bit left rotator
`timescale 1ns/1ps
module rmsu_rotl (
   input  wire logic [rmsu_pkg::DATA_W-1:0] data_in,
   input  wire logic [rmsu_pkg::CNT_W-1:0]  amount,
   output logic      [rmsu_pkg::DATA_W-1:0] rotated
);
   import rmsu_pkg::*;

   logic [2*DATA_W-1:0] wide;

   // Doubling the word turns the rotate into a plain shift
   assign wide    = {data_in, data_in} << amount;
   assign rotated = wide[2*DATA_W-1:DATA_W];

endmodule // rmsu_rotl

// ---- src/rmsu_top.sv ----
// Rotate, mask and shift unit with its AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// What this block does
// [RQ1] Build a 32-bit mask of ones from begin position through end position.
// [RQ2] When begin lies after end, the run of ones wraps round the word.
// [RQ3] Opcode 20: rotate source, insert into target under the mask.
// [RQ4] Opcode 21: rotate source by immediate, AND with mask, write target.
// [RQ5] Opcode 23: rotate by amount low five bits, AND with mask, write target.
// [RQ6] Extended 24: shift left with zero fill; overflow bit clears the target.
// [RQ7] Extended 792: arithmetic right shift, vacated bits copy the sign.
// [RQ8] Carry set when source negative and a one was shifted out.
// [RQ9] Overflow bit set: target bits and carry all equal the sign.
// [RQ10] Record bit updates condition field from result sign, zero, summary overflow.
// [RQ11] Opcode top six bits, register, mask fields below, record bit lowest.
module rmsu_top (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [rmsu_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [rmsu_pkg::DATA_W-1:0] wdata,
   input  wire logic [rmsu_pkg::STRB_W-1:0] wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic      [1:0]                  bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [rmsu_pkg::ADDR_W-1:0] araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic      [rmsu_pkg::DATA_W-1:0] rdata,
   output logic      [1:0]                  rresp,
   output logic                             rvalid,
   input  wire logic                        rready
);
   import rmsu_pkg::*;

   logic [DATA_W-1:0] instr;
   logic [DATA_W-1:0] src;
   logic [DATA_W-1:0] tgt;
   logic [DATA_W-1:0] amt;
   logic [EXC_W-1:0]  exc;
   logic [CR_W-1:0]   cond;
   logic              done;
   logic              illegal;
   logic              exec_pend;

   logic              aw_hold;
   logic              w_hold;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic              wr_fire;

   rmsu_op_e          op;
   logic [CNT_W-1:0]  rot_amt;
   logic [CNT_W-1:0]  mask_begin;
   logic [CNT_W-1:0]  mask_end;
   logic              mask_zero;
   logic [DATA_W-1:0] mask;
   logic [DATA_W-1:0] rotated;
   logic [DATA_W-1:0] result;
   logic              sign;
   logic              carry;
   logic              res_lt;
   logic              res_eq;
   logic              commit;

   logic [DATA_W-1:0] rd_word;
   logic              rd_ok;
   logic              wr_ok;
   logic [DATA_W-1:0] status_word;

   function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] v;
      v = old_v;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) begin
            v[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
         end
      end
      return v;
   endfunction

   // Instruction decode
   always_comb begin
      op = OP_NONE;
      unique case (instr[OPCD_HI:OPCD_LO]) // [RQ11]
         OPCD_INSERT: begin
            op = OP_INSERT;
         end
         OPCD_AND_IMM: begin
            op = OP_AND_IMM;
         end
         OPCD_AND_REG: begin
            op = OP_AND_REG;
         end
         OPCD_EXT: begin
            if (instr[XO_HI:XO_LO] == XO_SLW) begin
               op = OP_SLW;
            end else if (instr[XO_HI:XO_LO] == XO_SRAW) begin
               op = OP_SRAW;
            end
         end
         default: begin
            op = OP_NONE;
         end
      endcase
   end

   // Operand steering: every operation is a rotate plus a mask
   always_comb begin
      rot_amt    = instr[ROT_HI:ROT_LO];
      mask_begin = instr[MBEG_HI:MBEG_LO]; // [RQ11]
      mask_end   = instr[MEND_HI:MEND_LO];
      mask_zero  = 1'b0;
      unique case (op)
         OP_NONE, OP_INSERT, OP_AND_IMM: begin
            rot_amt = instr[ROT_HI:ROT_LO]; // [RQ3] [RQ4]
         end
         OP_AND_REG: begin
            rot_amt = amt[AMT_HI:AMT_LO]; // [RQ5]
         end
         OP_SLW: begin
            rot_amt    = amt[AMT_HI:AMT_LO]; // [RQ6]
            mask_begin = MASK_FIRST;
            mask_end   = MASK_LAST - amt[AMT_HI:AMT_LO];
            mask_zero  = amt[AMT_OVER];
         end
         OP_SRAW: begin
            rot_amt    = CNT_W'(ROT_WRAP - {1'b0, amt[AMT_HI:AMT_LO]}); // [RQ7]
            mask_begin = amt[AMT_HI:AMT_LO];
            mask_end   = MASK_LAST;
            mask_zero  = amt[AMT_OVER]; // [RQ9]
         end
      endcase
   end

   rmsu_rotl u_rotl (
      .data_in (src),
      .amount  (rot_amt),
      .rotated (rotated)
   );

   rmsu_mask_gen u_mask (
      .mask_begin (mask_begin),
      .mask_end   (mask_end),
      .mask_zero  (mask_zero),
      .mask       (mask)
   );

   assign sign = src[SIGN_BIT];

   always_comb begin
      result = tgt;
      unique case (op)
         OP_NONE: begin
            result = tgt;
         end
         OP_INSERT: begin
            result = (rotated & mask) | (tgt & ~mask); // [RQ3]
         end
         OP_AND_IMM, OP_AND_REG, OP_SLW: begin
            result = rotated & mask; // [RQ4] [RQ5] [RQ6]
         end
         OP_SRAW: begin
            result = (rotated & mask) | ({DATA_W{sign}} & ~mask); // [RQ7] [RQ9]
         end
      endcase
   end

   // Bits outside the mask are exactly the ones shifted out
   assign carry  = sign && (|(rotated & ~mask)); // [RQ8] [RQ9]
   assign res_lt = result[SIGN_BIT];
   assign res_eq = (result == RST_WORD);
   assign commit = exec_pend && (op != OP_NONE);

   // Write channel bookkeeping
   assign wr_fire = aw_hold && w_hold && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_hold <= 1'b0;
         wr_addr <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_hold <= 1'b1;
         wr_addr <= awaddr;
      end else if (wr_fire) begin
         aw_hold <= 1'b0;
      end else if (!aw_hold && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready  <= 1'b0;
         w_hold  <= 1'b0;
         wr_data <= RST_WORD;
         wr_strb <= '0;
      end else if (wvalid && wready) begin
         wready  <= 1'b0;
         w_hold  <= 1'b1;
         wr_data <= wdata;
         wr_strb <= wstrb;
      end else if (wr_fire) begin
         w_hold <= 1'b0;
      end else if (!w_hold && !bvalid) begin
         wready <= 1'b1;
      end
   end

   // Read-only registers accept writes silently
   always_comb begin
      unique case (wr_addr)
         OFS_INSTR, OFS_SRC, OFS_TGT, OFS_AMT, OFS_EXC, OFS_COND, OFS_STATUS: begin
            wr_ok = 1'b1;
         end
         default: begin
            wr_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Software-written operand registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr <= RST_WORD;
         src   <= RST_WORD;
         amt   <= RST_WORD;
      end else if (wr_fire) begin
         if (wr_addr == OFS_INSTR) begin
            instr <= merge_bytes(instr, wr_data, wr_strb);
         end
         if (wr_addr == OFS_SRC) begin
            src <= merge_bytes(src, wr_data, wr_strb);
         end
         if (wr_addr == OFS_AMT) begin
            amt <= merge_bytes(amt, wr_data, wr_strb);
         end
      end
   end

   // Execution is launched by the instruction write, one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exec_pend <= 1'b0;
         done      <= 1'b0;
         illegal   <= 1'b0;
      end else if (wr_fire && (wr_addr == OFS_INSTR)) begin
         exec_pend <= 1'b1;
         done      <= 1'b0;
         illegal   <= 1'b0;
      end else if (exec_pend) begin
         exec_pend <= 1'b0;
         done      <= 1'b1;
         illegal   <= (op == OP_NONE);
      end
   end

   // Hardware update wins over a software write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tgt <= RST_WORD;
      end else if (commit) begin
         tgt <= result; // [RQ3] [RQ4] [RQ5] [RQ6] [RQ7]
      end else if (wr_fire && (wr_addr == OFS_TGT)) begin
         tgt <= merge_bytes(tgt, wr_data, wr_strb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc <= '0;
      end else begin
         if (wr_fire && (wr_addr == OFS_EXC)) begin
            exc <= wr_strb[0] ? wr_data[EXC_W-1:0] : exc;
         end
         if (exec_pend && (op == OP_SRAW)) begin
            exc[EXC_CY] <= carry; // [RQ8] [RQ9]
         end
      end
   end

   // Record form: signed compare of the result against zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cond <= '0;
      end else if (commit && instr[REC_BIT]) begin
         cond[CR_LT] <= res_lt; // [RQ10]
         cond[CR_GT] <= !res_lt && !res_eq;
         cond[CR_EQ] <= res_eq;
         cond[CR_SO] <= exc[EXC_SO];
      end
   end

   // Read path
   always_comb begin
      status_word                       = RST_WORD;
      status_word[ST_DONE]              = done;
      status_word[ST_ILLEGAL]           = illegal;
      status_word[ST_TGT_HI:ST_TGT_LO]  = instr[TGT_HI:TGT_LO];
   end

   always_comb begin
      rd_word = RST_WORD;
      rd_ok   = 1'b1;
      unique case (araddr)
         OFS_INSTR: begin
            rd_word = instr;
         end
         OFS_SRC: begin
            rd_word = src;
         end
         OFS_TGT: begin
            rd_word = tgt;
         end
         OFS_AMT: begin
            rd_word = amt;
         end
         OFS_EXC: begin
            rd_word[EXC_W-1:0] = exc;
         end
         OFS_COND: begin
            rd_word[CR_W-1:0] = cond;
         end
         OFS_STATUS: begin
            rd_word = status_word;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= RST_WORD;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_word;
         rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

endmodule // rmsu_top

// ---- verif/rmsu_axi_bfm.sv ----
// Bus master model standing in for the pipeline side of the unit
`timescale 1ns/1ps
module rmsu_axi_bfm
   import rmsu_pkg::*;
(
   input  wire logic              aclk,
   output logic      [ADDR_W-1:0] awaddr,
   output logic                   awvalid,
   input  wire logic              awready,
   output logic      [DATA_W-1:0] wdata,
   output logic      [STRB_W-1:0] wstrb,
   output logic                   wvalid,
   input  wire logic              wready,
   input  wire logic [1:0]        bresp,
   input  wire logic              bvalid,
   output logic                   bready,
   output logic      [ADDR_W-1:0] araddr,
   output logic                   arvalid,
   input  wire logic              arready,
   input  wire logic [DATA_W-1:0] rdata,
   input  wire logic [1:0]        rresp,
   input  wire logic              rvalid,
   output logic                   rready
);
   localparam int LIMIT = 60;
   logic hung = 1'b0;
   int   slow = 0;
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, wstrb, araddr} = '0;
   end
   // Released lines show the inverse so stale values cannot pass
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [1:0] resp);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= '1;
      wvalid  <= 1'b1;
      resp = 2'bxx;
      for (i = 0; i < LIMIT; i++) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr  <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata  <= ~d;
         end
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
         if (i >= slow) bready <= 1'b1;
      end
      if (i == LIMIT) hung = 1'b1;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                     output logic [1:0] resp);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      d = 'x;
      resp = 2'bxx;
      for (i = 0; i < LIMIT; i++) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr  <= ~a;
         end
         if (rvalid && rready) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
         if (i >= slow) rready <= 1'b1;
      end
      if (i == LIMIT) hung = 1'b1;
   endtask
endmodule // rmsu_axi_bfm

// ---- verif/rmsu_top_sva.sv ----
// Bus handshake checker for the rotate, mask and shift unit
`timescale 1ns/1ps
module rmsu_top_sva
   import rmsu_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_take; awvalid && awready; endsequence
   sequence w_take; wvalid && wready; endsequence
   sequence ar_take; arvalid && arready; endsequence
   AST_B_LAT: assert property (aw_take and w_take |=> !bvalid ##1 bvalid)
      else $error("write answer not two cycles after take");
   AST_R_LAT: assert property (ar_take |=> rvalid && !arready)
      else $error("read answer not one cycle after take");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before taken");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer changed before taken");
   AST_AW_DROP: assert property (aw_take |=> !awready)
      else $error("write address ready stayed high");
   AST_W_DROP: assert property (w_take |=> !wready)
      else $error("write data ready stayed high");
   AST_R_DONE: assert property (rvalid && rready |=> !rvalid ##[1:2] arready)
      else $error("read channel did not reopen");
   AST_B_DONE: assert property (bvalid && bready |=> !bvalid ##[1:2] (awready && wready))
      else $error("write channel did not reopen");
   AST_ERR_ZERO: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == RST_WORD)
      else $error("refused read returned data");
   AST_RST_IDLE: assert property ($rose(aresetn) |-> !bvalid && !rvalid)
      else $error("answer pending out of reset");
endmodule // rmsu_top_sva
bind rmsu_top rmsu_top_sva chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// ---- verif/rmsu_top_tb.sv ----
// Self-checking bench for the rotate, mask and shift unit
`timescale 1ns/1ps
module rmsu_top_tb;
   import rmsu_pkg::*;
   typedef logic [DATA_W-1:0] rmsu_word_t;
   typedef struct {rmsu_word_t ins, src, tgt, amt; logic so;} rmsu_row_s;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [STRB_W-1:0] wstrb;
   logic [1:0]        bresp, rresp;
   rmsu_word_t        wdata, rdata;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [3:0]        cr = '0;
   int                err_count = 0;
   int                cmp_count = 0;
   rmsu_row_s         rows [15];
   rmsu_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);
   rmsu_axi_bfm bus (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready);
   initial forever #50 aclk = ~aclk;
   task automatic final_report();
      if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input rmsu_word_t seen, input rmsu_word_t exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input rmsu_word_t d, input logic [1:0] er);
      logic [1:0] r;
      bus.wr(a, d, r);
      if (bus.hung) begin
         err_count++;
         final_report();
      end else chk(32'(r), 32'(er));
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input rmsu_word_t exp, input logic [1:0] er);
      rmsu_word_t d;
      logic [1:0] r;
      bus.rd(a, d, r);
      if (bus.hung) begin
         err_count++;
         final_report();
      end else begin
         chk(d, exp);
         chk(32'(r), 32'(er));
      end
   endtask
   function automatic rmsu_word_t rotl(rmsu_word_t v, int n);
      return (v << n) | (v >> ((32 - n) % 32));
   endfunction
   // Position 0 is the most significant bit
   function automatic rmsu_word_t mask(int b, int e);
      rmsu_word_t m = '0;
      for (int i = 0; i < 32; i++)
         if (b <= e ? (i >= b && i <= e) : (i >= b || i <= e)) m[31-i] = 1'b1;
      return m;
   endfunction
   function automatic rmsu_word_t mi(logic [5:0] op, logic [4:0] rot, logic [4:0] b,
                                     logic [4:0] e, logic rec);
      return {op, 5'h00, 5'h03, rot, b, e, rec};
   endfunction
   function automatic rmsu_word_t xi(logic [9:0] xo, logic rec);
      return {6'h1f, 5'h00, 5'h03, 5'h00, xo, rec};
   endfunction
   task automatic run(input rmsu_row_s r);
      rmsu_word_t m, res;
      int n;
      logic s, cy, bad;
      m = mask(r.ins[10:6], r.ins[5:1]);
      n = r.amt[4:0];
      s = r.src[31];
      {res, cy, bad} = {r.tgt, 2'b10};
      case (r.ins[31:26])
         6'h14: res = (rotl(r.src, r.ins[15:11]) & m) | (r.tgt & ~m);
         6'h15: res = rotl(r.src, r.ins[15:11]) & m;
         6'h17: res = rotl(r.src, n) & m;
         6'h1f: if (r.ins[10:1] == 10'h018) res = r.amt[5] ? '0 : r.src << n;
         else if (r.ins[10:1] == 10'h318) begin
            res = r.amt[5] ? {32{s}} : rmsu_word_t'($signed(r.src) >>> n);
            cy = s && (r.amt[5] || (r.src & ~(32'hffff_ffff << n)) != 0);
         end else bad = 1'b1;
         default: bad = 1'b1;
      endcase
      wr(OFS_SRC, r.src, RESP_OKAY);
      wr(OFS_TGT, r.tgt, RESP_OKAY);
      wr(OFS_AMT, r.amt, RESP_OKAY);
      wr(OFS_EXC, {30'h0, r.so, 1'b1}, RESP_OKAY);
      wr(OFS_INSTR, r.ins, RESP_OKAY);
      if (!bad && r.ins[0]) cr = {$signed(res) < 0, $signed(res) > 0, res == 0, r.so};
      rd(OFS_TGT, res, RESP_OKAY);
      rd(OFS_EXC, {30'h0, r.so, cy}, RESP_OKAY);
      rd(OFS_COND, {28'h0, cr}, RESP_OKAY);
      rd(OFS_STATUS, {19'h0, r.ins[20:16], 6'h0, bad, 1'b1}, RESP_OKAY);
   endtask
   initial begin
      rows = '{
         '{mi(6'h14, 5'd8, 5'd28, 5'd3, 1'b0), 32'h1234_5678, 32'hcafe_f00d, 32'h0, 1'b0},
         '{mi(6'h14, 5'd31, 5'd0, 5'd31, 1'b1), 32'h8000_0001, 32'h0, 32'h0, 1'b1},
         '{mi(6'h15, 5'd4, 5'd5, 5'd5, 1'b1), 32'h0f0f_0f0f, 32'hffff_ffff, 32'h0, 1'b0},
         '{mi(6'h15, 5'd0, 5'd31, 5'd0, 1'b1), 32'h8000_0001, 32'h0, 32'h0, 1'b0},
         '{mi(6'h17, 5'd0, 5'd16, 5'd31, 1'b1), 32'h89ab_cdef, 32'h0, 32'hffff_ffe5, 1'b0},
         '{xi(10'h018, 1'b1), 32'h8000_0001, 32'h5, 32'h0, 1'b0},
         '{xi(10'h018, 1'b0), 32'hffff_ffff, 32'h5, 32'h1f, 1'b0},
         '{xi(10'h018, 1'b1), 32'hffff_ffff, 32'h5, 32'h20, 1'b1},
         '{xi(10'h318, 1'b1), 32'h8000_0003, 32'h5, 32'h1, 1'b0},
         '{xi(10'h318, 1'b0), 32'h8000_0000, 32'h5, 32'h4, 1'b0},
         '{xi(10'h318, 1'b1), 32'h7fff_ffff, 32'h5, 32'h1f, 1'b0},
         '{xi(10'h318, 1'b0), 32'h8000_0000, 32'h5, 32'h3f, 1'b0},
         '{xi(10'h318, 1'b1), 32'h4000_0000, 32'h5, 32'h20, 1'b0},
         '{mi(6'h00, 5'd1, 5'd2, 5'd3, 1'b1), 32'h1, 32'h77, 32'h0, 1'b0},
         '{xi(10'h019, 1'b1), 32'h1, 32'h66, 32'h0, 1'b0}};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), '0, RESP_OKAY);
      foreach (rows[i]) run(rows[i]);
      // Refused and ignored accesses, with the master answering late
      bus.slow = 3;
      rd(8'h1c, '0, RESP_SLVERR);
      wr(8'h02, 32'hffff_ffff, RESP_SLVERR);
      wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
      wr(OFS_COND, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_COND, {28'h0, cr}, RESP_OKAY);
      bus.slow = 0;
      // Second reset in mid-run clears the results
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_TGT, '0, RESP_OKAY);
      rd(OFS_COND, '0, RESP_OKAY);
      final_report();
   end
endmodule // rmsu_top_tb
